// File: sim/operand_specifier_address_calc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module operand_specifier_address_calc_tb_top;
  logic                  pclk = 1'b0;
  // starts high so the async reset sees a falling edge
  logic                  presetn = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic                  start = 1'b0;
  osa_pkg::osa_size_t    op_size = osa_pkg::OSA_BYTE;
  logic [31:0]           start_pc = 32'h0;
  osa_pkg::osa_apb_rsp_t apb_rsp;
  osa_pkg::osa_result_t  result;
  logic                  busy, spec_valid, spec_ready, mem_req, mem_ack, irq, err;
  logic [7:0]            spec_byte;
  logic [3:0]            reg_sel;
  logic [31:0]           reg_value, mem_addr, mem_rdata, rd;
  int                    miscompares = 0;
  int                    num_checks = 0;
  int                    cycles = 0;

  osa_eval u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .apb_rsp, .start, .op_size,
    .start_pc, .busy, .spec_valid, .spec_byte, .spec_ready, .reg_sel, .reg_value, .mem_req, .mem_addr,
    .mem_ack, .mem_rdata, .result, .irq);
  osa_far_model u_far (.pclk, .presetn, .spec_valid, .spec_byte, .spec_ready, .reg_sel, .reg_value,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata);

  initial forever #12.5 pclk = ~pclk;

  // whole run needs well under 2000 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] e, input logic [63:0] a);
    num_checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("Error t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // queue bytes at the far side, start, wait for the result pulse
  task automatic run(input osa_pkg::osa_size_t sz, input logic [31:0] pc, input logic [39:0] b, input int n);
    for (int i = 0; i < n; i++)
      u_far.stream[u_far.len + i] = b[8*i +: 8];
    u_far.len += n;
    @(posedge pclk);
    start <= 1'b1;
    op_size <= sz;
    start_pc <= pc;
    @(posedge pclk);
    start <= 1'b0;
    // only the bench timeout ends a wait that never sees the pulse
    do
    begin
      @(posedge pclk);
      #1;
    end
    while (result.valid !== 1'b1);
  endtask

  task automatic t_regs();
    apb(1'b0, osa_pkg::CTRL_OFS, 32'h0);
    chk(64'h1, rd);
    apb(1'b0, osa_pkg::IRQ_MASK_OFS, 32'h0);
    chk(64'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk(64'h1, err);
    apb(1'b1, osa_pkg::IRQ_MASK_OFS, 32'h6);
    apb(1'b0, osa_pkg::IRQ_MASK_OFS, 32'h0);
    chk(64'h6, rd);
  endtask

  task automatic t_lit();
    run(osa_pkg::OSA_BYTE, 32'h0, 40'h24, 1);
    chk(64'h24, result.value);
    chk(64'h1, result.is_literal);
    run(osa_pkg::OSA_FLOAT, 32'h0, 40'h24, 1);
    chk(64'h4240, result.value);
    run(osa_pkg::OSA_DOUBLE, 32'h0, 40'h3f, 1);
    chk(64'h43f0, result.value);
    run(osa_pkg::OSA_FLOAT, 32'h0, 40'h00, 1);
    chk(64'h4000, result.value);
  endtask

  task automatic t_offset_extension();
    u_far.regs[4] = 32'h1012;
    run(osa_pkg::OSA_BYTE, 32'h3001, 40'h05a4, 2);
    chk(64'h1017, result.addr);
    run(osa_pkg::OSA_BYTE, 32'h3001, 40'hfba4, 2);
    chk(64'h100d, result.addr);
    run(osa_pkg::OSA_BYTE, 32'h3001, 40'hfffec4, 3);
    chk(64'h1010, result.addr);
    run(osa_pkg::OSA_BYTE, 32'h3001, 40'h00010000e4, 5);
    chk(64'h11012, result.addr);
    run(osa_pkg::OSA_BYTE, 32'h3001, 40'h10af, 2);
    chk(64'h3013, result.addr);
    apb(1'b0, osa_pkg::LAST_ADDR_OFS, 32'h0);
    chk(64'h3013, rd);
  endtask

  task automatic t_defer();
    u_far.regs[3] = 32'h2000;
    u_far.mem_lat = 3;
    run(osa_pkg::OSA_LONG, 32'h0, 40'h04b3, 2);
    chk(64'h01002004, result.addr);
    u_far.mem_lat = 0;
    run(osa_pkg::OSA_LONG, 32'h0, 40'h0100d3, 3);
    chk(64'h01002100, result.addr);
  endtask

  task automatic t_index();
    u_far.regs[2] = 32'h1012;
    u_far.regs[5] = 32'h3;
    // index register never equals the base register
    for (int i = 0; i < 6; i++)
    begin
      run(osa_pkg::osa_size_t'(i), 32'h0, 40'h6245, 2);
      chk(32'h1012 + 3 * (i < 2 ? i + 1 : i < 4 ? 4 : 8), result.addr);
    end
    run(osa_pkg::OSA_LONG, 32'h0, 40'h05a445, 3);
    chk(64'h1023, result.addr);
  endtask

  task automatic t_faults();
    logic [7:0] bad [4] = '{8'h05, 8'h55, 8'h45, 8'h6f};
    run(osa_pkg::OSA_LONG, 32'h0, 40'h4f, 1);
    chk(osa_pkg::OSA_RESERVED, result.fault);
    apb(1'b0, osa_pkg::IRQ_STAT_OFS, 32'h0);
    chk(64'h1, rd[osa_pkg::EV_RESERVED_BIT]);
    chk(64'h1, irq);
    apb(1'b1, osa_pkg::IRQ_STAT_OFS, 32'hf);
    apb(1'b0, osa_pkg::IRQ_STAT_OFS, 32'h0);
    chk(64'h0, rd);
    chk(64'h0, irq);
    for (int i = 0; i < 4; i++)
    begin
      run(osa_pkg::OSA_LONG, 32'h0, {24'h0, bad[i], 8'h45}, 2);
      chk(osa_pkg::OSA_ILLEGAL, result.fault);
    end
    apb(1'b0, osa_pkg::STATUS_OFS, 32'h0);
    chk(64'h1, irq);
    chk(64'h4, rd);
    apb(1'b1, osa_pkg::IRQ_STAT_OFS, 32'hf);
    // completion alone is masked, so irq must stay low
    run(osa_pkg::OSA_BYTE, 32'h0, 40'h01, 1);
    apb(1'b0, osa_pkg::STATUS_OFS, 32'h0);
    chk(64'h0, irq);
    chk(64'h0, rd);
    apb(1'b1, osa_pkg::CTRL_OFS, 32'h0);
    @(posedge pclk);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    #1;
    chk(64'h0, busy);
    apb(1'b1, osa_pkg::CTRL_OFS, 32'h1);
  endtask

  initial
  begin
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lit();
    t_offset_extension();
    t_defer();
    t_index();
    t_faults();
    finish_test();
  end
endmodule
`default_nettype wire

// File: sim/osa_eval_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module osa_eval_asserts (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire osa_pkg::osa_apb_rsp_t apb_rsp,
  // evaluation
  input wire logic                  start,
  input wire osa_pkg::osa_size_t    op_size,
  input wire logic                  busy,
  input wire logic                  spec_valid,
  input wire logic [7:0]            spec_byte,
  input wire logic                  spec_ready,
  input wire logic [3:0]            reg_sel,
  input wire logic [31:0]           reg_value,
  input wire logic                  mem_req,
  input wire logic [31:0]           mem_addr,
  input wire logic                  mem_ack,
  input wire logic [31:0]           mem_rdata,
  input wire osa_pkg::osa_result_t  result
);
  logic [2:0]         nb;
  logic [7:0]         b0;
  logic [7:0]         b1;
  osa_pkg::osa_size_t sz;
  wire logic          take = busy && spec_valid && spec_ready;
  wire logic          flt = sz == osa_pkg::OSA_FLOAT || sz == osa_pkg::OSA_DOUBLE;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bytes taken in this evaluation, first two kept
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) nb <= 3'h0;
    else nb <= !busy ? 3'h0 : nb + 3'(take);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) b0 <= 8'h00;
    else if (take && nb == 3'h0) b0 <= spec_byte;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) b1 <= 8'h00;
    else if (take && nb == 3'h1) b1 <= spec_byte;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sz <= osa_pkg::OSA_BYTE;
    else if (start && !busy) sz <= op_size;

  chk_apb_one_wait: assert property (psel && !penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb answer timing wrong");
  chk_busy_done: assert property (result.valid |-> !busy)
    else $error("busy high at result");
  chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped");
  chk_int_literal: assert property (take && nb == 3'h0 && spec_byte[7:6] == 2'b00 && !flt |=>
    result.valid && result.is_literal && result.value == {58'h0, b0[5:0]}) else $error("literal wrong");
  chk_float_literal: assert property (take && nb == 3'h0 && spec_byte[7:6] == 2'b00 && flt |=>
    result.valid && result.value == (64'h4000 | {54'h0, b0[5:0], 4'h0})) else $error("float literal wrong");
  chk_offset_extension_sum: assert property (take && nb == 3'h1 && b0[7:4] == 4'ha && b0[3:0] != 4'hf |=>
    reg_sel == b0[3:0] ##1 result.valid && result.addr == $past(reg_value) + {{24{b1[7]}}, b1})
    else $error("displacement address wrong");
  chk_defer_addr: assert property (mem_ack && mem_req && b0[7:4] != 4'h4 |=>
    result.valid && result.addr == $past(mem_rdata)) else $error("deferred address wrong");
  chk_pc_index: assert property (take && nb == 3'h0 && spec_byte == 8'h4f |->
    ##[1:4] result.valid && result.fault == osa_pkg::OSA_RESERVED) else $error("no reserved fault");
  chk_bad_base: assert property (take && nb == 3'h1 && b0[7:4] == 4'h4 && b0[3:0] != 4'hf &&
    (spec_byte[7:6] == 2'b00 || spec_byte[7:4] inside {4'h4, 4'h5}) |->
    ##[1:4] result.valid && result.fault == osa_pkg::OSA_ILLEGAL) else $error("no illegal fault");
endmodule

bind osa_eval osa_eval_asserts u_chk (.pclk, .presetn, .psel, .penable, .apb_rsp, .start, .op_size, .busy,
  .spec_valid, .spec_byte, .spec_ready, .reg_sel, .reg_value, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .result);
`default_nettype wire

// File: sim/osa_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module osa_far_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // specifier stream
  output logic             spec_valid,
  output logic [7:0]       spec_byte,
  input  wire logic        spec_ready,
  // registers and memory
  input  wire logic [3:0]  reg_sel,
  output logic [31:0]      reg_value,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [7:0]  stream [256];
  logic [31:0] regs [16];
  logic [7:0]  last = 8'h00;
  int          len = 0;
  int          ptr = 0;
  int          cnt = 0;
  int          mem_lat = 0;

  assign reg_value = regs[reg_sel];
  assign spec_valid = ptr < len;
  // idle byte lane never repeats the last byte
  assign spec_byte = spec_valid ? stream[ptr] : ~last;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 0;
    end
    else
    begin
      if (spec_valid && spec_ready)
      begin
        ptr <= ptr + 1;
        last <= spec_byte;
      end
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
      if (mem_req && !mem_ack && cnt >= mem_lat)
      begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr + 32'h0100_0000;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/osa_eval.sv
`timescale 1ns/1ps
`default_nettype none

module osa_eval (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  osa_pkg::osa_apb_rsp_t apb_rsp,
  // evaluation request
  input  wire logic                 start,
  input  wire osa_pkg::osa_size_t   op_size,
  input  wire logic [31:0]          start_pc,
  output logic                      busy,
  // specifier byte stream
  input  wire logic                 spec_valid,
  input  wire logic [7:0]           spec_byte,
  output logic                      spec_ready,
  // general register read
  output logic [3:0]                reg_sel,
  input  wire logic [31:0]          reg_value,
  // longword memory read
  output logic                      mem_req,
  output logic [31:0]               mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  // result and interrupt
  output var  osa_pkg::osa_result_t result,
  output logic                      irq
);

  typedef enum logic [2:0] {
    S_IDLE, S_SPEC, S_OFFSET_EXTENSION, S_BASE, S_MEM, S_INDEX, S_SCALE
  } osa_state_t;

  typedef struct packed {
    osa_state_t            st;
    osa_pkg::osa_size_t    size;
    logic [31:0]           pc;
    logic [3:0]            mode;
    logic [3:0]            base_register;
    logic [3:0]            index_reg;
    logic                  in_index;
    logic                  deferred;
    logic [31:0]           offset_extension;
    logic [1:0]            offset_extension_cnt;
    logic [1:0]            offset_extension_last;
    logic [31:0]           addr;
    logic                  ctrl_en;
    logic [osa_pkg::EV_W-1:0] irq_stat;
    logic [osa_pkg::EV_W-1:0] irq_mask;
    logic [31:0]           last_addr;
    osa_pkg::osa_fault_t   last_fault;
    osa_pkg::osa_apb_rsp_t apb;
    osa_pkg::osa_result_t  res;
    logic                  spec_ready;
    logic [3:0]            reg_sel;
    logic                  mem_req;
    logic                  irq;
    logic                  busy;
  } osa_regs_t;

  osa_regs_t r;
  osa_regs_t next_r;

  // index shift for operand size
  function automatic logic [1:0] size_shift(input osa_pkg::osa_size_t s);
    unique case (s)
      osa_pkg::OSA_BYTE:                     size_shift = 2'd0;
      osa_pkg::OSA_WORD:                     size_shift = 2'd1;
      osa_pkg::OSA_LONG, osa_pkg::OSA_FLOAT: size_shift = 2'd2;
      default:                               size_shift = 2'd3;
    endcase
  endfunction

  // offset bytes minus one for modes a..f
  function automatic logic [1:0] offset_extension_bytes(input logic [3:0] mode);
    unique case (mode[2:1])
      2'b01:   offset_extension_bytes = 2'd0;
      2'b10:   offset_extension_bytes = 2'd1;
      default: offset_extension_bytes = 2'd3;
    endcase
  endfunction

  // pc in register deferred or autodecrement is unpredictable
  function automatic logic spec_unpredictable(input logic [7:0] b);
    spec_unpredictable = (b[7:4] == osa_pkg::MODE_REG_DEF || b[7:4] == osa_pkg::MODE_AUTODEC)
                         && b[3:0] == osa_pkg::PC_REG;
  endfunction

  function automatic logic [63:0] expand_literal(input logic [5:0] lit, input osa_pkg::osa_size_t s);
    logic [2:0]  literal_exponent_field;
    logic [2:0]  literal_fraction_field;
    logic [63:0] v;
    literal_exponent_field = lit[5:3];
    literal_fraction_field = lit[2:0];
    v = 64'h0;
    if (s == osa_pkg::OSA_FLOAT || s == osa_pkg::OSA_DOUBLE)
    begin
      v[osa_pkg::FLT_EXP_LSB +: 8] = osa_pkg::EXP_BIAS;
      v[osa_pkg::FLT_EXP_LSB +: 3] = literal_exponent_field;
      v[osa_pkg::FLT_LITERAL_FRACTION_FIELD_LSB +: 3] = literal_fraction_field;
    end
    else
    begin
      v[5:0] = lit;
    end
    v[63:32] = (s == osa_pkg::OSA_FLOAT) ? 32'h0 : v[63:32];
    expand_literal = v;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input osa_regs_t q);
    unique case (a)
      osa_pkg::CTRL_OFS:      reg_read = {31'h0, q.ctrl_en};
      osa_pkg::STATUS_OFS:    reg_read = {28'h0, q.last_fault, 1'b0, q.st != S_IDLE};
      osa_pkg::IRQ_STAT_OFS:  reg_read = {28'h0, q.irq_stat};
      osa_pkg::IRQ_MASK_OFS:  reg_read = {28'h0, q.irq_mask};
      osa_pkg::LAST_ADDR_OFS: reg_read = q.last_addr;
      default:                reg_read = 32'h0;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = a == osa_pkg::CTRL_OFS || a == osa_pkg::STATUS_OFS || a == osa_pkg::IRQ_STAT_OFS
                 || a == osa_pkg::IRQ_MASK_OFS || a == osa_pkg::LAST_ADDR_OFS;
  endfunction

  always_comb
  begin
    logic [osa_pkg::EV_W-1:0] ev;
    logic                     finish;
    osa_pkg::osa_fault_t      fault;
    logic [31:0]              base_val;
    logic [31:0]              sext;
    ev       = '0;
    finish   = 1'b0;
    fault    = osa_pkg::OSA_OK;
    base_val = 32'h0;
    sext     = 32'h0;
    next_r   = r;
    next_r.res.valid = 1'b0;

    unique case (r.st)
      S_IDLE:
      begin
        if (start && r.ctrl_en)
        begin
          next_r.st       = S_SPEC;
          next_r.size     = op_size;
          next_r.pc       = start_pc;
          next_r.in_index = 1'b0;
          next_r.res.is_literal = 1'b0;
          next_r.res.value      = 64'h0;
        end
      end
      S_SPEC:
      begin
        if (spec_valid && r.spec_ready)
        begin
          next_r.pc            = r.pc + 32'd1;
          next_r.mode          = spec_byte[7:4];
          next_r.base_register = spec_byte[3:0];
          next_r.deferred      = spec_byte[4];
          next_r.offset_extension_cnt      = 2'd0;
          next_r.offset_extension_last     = offset_extension_bytes(spec_byte[7:4]);
          next_r.offset_extension = 32'h0;
          if (spec_byte[7:6] == osa_pkg::LITERAL_TAG)
          begin
            fault                 = r.in_index ? osa_pkg::OSA_ILLEGAL : osa_pkg::OSA_OK;
            next_r.res.is_literal = !r.in_index;
            next_r.res.value      = r.in_index ? 64'h0 : expand_literal(spec_byte[5:0], r.size);
            finish = 1'b1;
          end
          else if (spec_byte[7:4] == osa_pkg::MODE_INDEX)
          begin
            if (r.in_index)
            begin
              fault  = osa_pkg::OSA_ILLEGAL;
              finish = 1'b1;
            end
            else if (spec_byte[3:0] == osa_pkg::PC_REG)
            begin
              fault  = osa_pkg::OSA_RESERVED;
              finish = 1'b1;
            end
            else
            begin
              next_r.in_index  = 1'b1;
              next_r.index_reg = spec_byte[3:0];
            end
          end
          else if (spec_byte[7:4] == osa_pkg::MODE_REGISTER && r.in_index)
          begin
            fault  = osa_pkg::OSA_ILLEGAL;
            finish = 1'b1;
          end
          else if (spec_unpredictable(spec_byte))
          begin
            fault  = r.in_index ? osa_pkg::OSA_ILLEGAL : osa_pkg::OSA_UNSUPPORTED;
            finish = 1'b1;
          end
          else if (spec_byte[7:4] == osa_pkg::MODE_REG_DEF && r.in_index)
          begin
            next_r.st = S_BASE;
          end
          else if (spec_byte[7])
          begin
            if (spec_byte[7:5] == 3'b100)
            begin
              // autoincrement forms (modes 8 and 9) are not supported and fault
              fault  = osa_pkg::OSA_UNSUPPORTED;
              finish = 1'b1;
            end
            else
            begin
              next_r.st = S_OFFSET_EXTENSION;
            end
          end
          else
          begin
            fault  = osa_pkg::OSA_UNSUPPORTED;
            finish = 1'b1;
          end
        end
      end
      S_OFFSET_EXTENSION:
      begin
        if (spec_valid && r.spec_ready)
        begin
          // little-endian assembly of the offset
          next_r.pc = r.pc + 32'd1;
          next_r.offset_extension[{r.offset_extension_cnt, 3'b000} +: 8] = spec_byte;
          next_r.offset_extension_cnt = r.offset_extension_cnt + 2'd1;
          if (r.offset_extension_cnt == r.offset_extension_last)
          begin
            next_r.st = S_BASE;
          end
        end
      end
      S_BASE:
      begin
        base_val = (r.base_register == osa_pkg::PC_REG) ? r.pc : reg_value;
        unique case (r.offset_extension_last)
          2'd0:    sext = {{24{r.offset_extension[7]}}, r.offset_extension[7:0]};
          2'd1:    sext = {{16{r.offset_extension[15]}}, r.offset_extension[15:0]};
          default: sext = r.offset_extension;
        endcase
        next_r.addr = base_val + sext;
        next_r.st = r.deferred ? S_MEM : S_INDEX;
        finish    = !r.deferred && !r.in_index;
      end
      S_MEM:
      begin
        if (mem_ack)
        begin
          next_r.addr = mem_rdata;
          next_r.st   = S_INDEX;
          finish      = !r.in_index;
        end
      end
      S_INDEX:
      begin
        // register select settles for one cycle
        next_r.st = S_SCALE;
      end
      S_SCALE:
      begin
        next_r.addr = r.addr + (reg_value << size_shift(r.size));
        finish = 1'b1;
      end
      default:
      begin
        next_r.st = S_IDLE;
      end
    endcase

    if (finish)
    begin
      next_r.st         = S_IDLE;
      next_r.res.valid  = 1'b1;
      next_r.res.fault  = fault;
      next_r.last_fault = fault;
      next_r.res.addr   = next_r.addr;
      next_r.last_addr = next_r.res.addr;
      unique case (fault)
        osa_pkg::OSA_OK:       ev[osa_pkg::EV_DONE_BIT]     = 1'b1;
        osa_pkg::OSA_ILLEGAL:  ev[osa_pkg::EV_ILLEGAL_BIT]  = 1'b1;
        osa_pkg::OSA_RESERVED: ev[osa_pkg::EV_RESERVED_BIT] = 1'b1;
        default:               ev[osa_pkg::EV_UNSUP_BIT]    = 1'b1;
      endcase
    end

    // port drives follow the next state so they come from flops
    next_r.spec_ready = next_r.st == S_SPEC || next_r.st == S_OFFSET_EXTENSION;
    next_r.mem_req    = next_r.st == S_MEM;
    next_r.busy       = next_r.st != S_IDLE;
    next_r.reg_sel    = (next_r.st == S_INDEX || next_r.st == S_SCALE) ? next_r.index_reg : next_r.base_register;

    // apb: answer in the first access cycle
    next_r.apb.pready = 1'b0;
    if (psel && !penable)
    begin
      next_r.apb.pready  = 1'b1;
      next_r.apb.pslverr = !reg_mapped(paddr);
      next_r.apb.prdata  = pwrite ? 32'h0 : reg_read(paddr, r);
    end
    if (psel && penable && r.apb.pready && pwrite)
    begin
      unique case (paddr)
        osa_pkg::CTRL_OFS:     next_r.ctrl_en  = pwdata[osa_pkg::CTRL_EN_BIT];
        osa_pkg::IRQ_MASK_OFS: next_r.irq_mask = pwdata[osa_pkg::EV_W-1:0];
        osa_pkg::IRQ_STAT_OFS: next_r.irq_stat = r.irq_stat & ~pwdata[osa_pkg::EV_W-1:0];
        default:               next_r.ctrl_en  = r.ctrl_en;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.st       <= S_IDLE;
      r.ctrl_en  <= osa_pkg::CTRL_EN_RST;
      r.irq_mask <= osa_pkg::IRQ_MASK_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign apb_rsp    = r.apb;
  assign result     = r.res;
  assign busy       = r.busy;
  assign spec_ready = r.spec_ready;
  assign reg_sel    = r.reg_sel;
  assign mem_req    = r.mem_req;
  assign mem_addr   = r.addr;
  assign irq        = r.irq;

endmodule

`default_nettype wire

// File: src/osa_pkg.sv
package osa_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
  localparam logic [7:0] LAST_ADDR_OFS = 8'h10;

  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int EV_DONE_BIT    = 0;
  localparam int EV_ILLEGAL_BIT = 1;
  localparam int EV_RESERVED_BIT = 2;
  localparam int EV_UNSUP_BIT   = 3;
  localparam int EV_W           = 4;

  // reset values
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // specifier encodings
  localparam logic [3:0] MODE_INDEX    = 4'h4;
  localparam logic [3:0] MODE_REGISTER = 4'h5;
  localparam logic [3:0] MODE_REG_DEF  = 4'h6;
  localparam logic [3:0] MODE_AUTODEC  = 4'h7;
  localparam logic [3:0] PC_REG        = 4'hf;
  localparam logic [1:0] LITERAL_TAG   = 2'b00;

  // floating literal layout
  localparam logic [7:0] EXP_BIAS      = 8'h80;
  localparam int         FLT_EXP_LSB   = 7;
  localparam int         FLT_LITERAL_FRACTION_FIELD_LSB  = 4;

  typedef enum logic [2:0] {
    OSA_BYTE, OSA_WORD, OSA_LONG, OSA_FLOAT, OSA_QUAD, OSA_DOUBLE
  } osa_size_t;

  typedef enum logic [1:0] {
    OSA_OK, OSA_ILLEGAL, OSA_RESERVED, OSA_UNSUPPORTED
  } osa_fault_t;

  // result carried to the execution stage
  typedef struct packed {
    logic        valid;
    logic        is_literal;
    osa_fault_t  fault;
    logic [31:0] addr;
    logic [63:0] value;
  } osa_result_t;

  // apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } osa_apb_rsp_t;

endpackage
